// *** verilog/p2io_pkg.sv ***
// Package for the port two I/O block: register map, resets, field codes
`default_nettype none
package p2io_pkg;

    // Register byte addresses (lower 16 bits)
    localparam logic [15:0] ADDR_DIRECTION    = 16'hFEB1;
    localparam logic [15:0] ADDR_PIN_LEVEL    = 16'hFF51;
    localparam logic [15:0] ADDR_OUTPUT_LATCH = 16'hFF61;

    // Reset values of the stored registers
    localparam logic [7:0] DIRECTION_RESET    = 8'h00;
    localparam logic [7:0] OUTPUT_LATCH_RESET = 8'h00;

    // Value returned by a read of the write-only direction register
    localparam logic [7:0] DIRECTION_READ_VALUE = 8'h00;
    // Value returned for an unmapped address
    localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

    // Pin positions of the multiplexed pins
    localparam int PIN_CHAN5_B = 7;
    localparam int PIN_CHAN5_A = 6;
    localparam int PIN_CHAN4_B = 5;

    // Channel mode field codes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PWM1   = 4'h2;
    localparam logic [3:0] MODE_PWM2   = 4'h3;
    localparam logic [1:0] MODE_PHASE_TOP = 2'h1;

    // Counter-clear codes that stop the PWM 2 output on each pin
    localparam logic [1:0] CCLR_STOPS_A = 2'h1;
    localparam logic [1:0] CCLR_STOPS_B = 2'h2;

    // Timer clock-select codes at or above this pick the external clock
    localparam logic [2:0] CKS_EXT_FIRST = 3'h5;

    // Settings of one pulse-unit channel
    typedef struct packed {
        logic [3:0] channel_mode_field;
        logic [3:0] a_io_control_field;
        logic [3:0] b_io_control_field;
        logic [1:0] counter_clear_select;
    } p2io_chan_cfg_s;

    // Register state of the port
    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] output_latch;
        logic [7:0] pin_sample;
        logic [7:0] rdata;
    } p2io_state_s;

endpackage : p2io_pkg
`default_nettype wire

// *** verilog/p2io_port.sv ***
// Port two I/O: registers, pin-state read and timer pin multiplexing
//
// Contract
// - Direction bit one drives, zero inputs
// - Direction register write-only, reads undefined
// - Direction and latch clear on power-on/standby
// - Output latch is readable and writable
// - Manual reset leaves pins to port registers
// - Pin-state register ignores writes
// - Output bits read back the latch
// - Input bits read the pin level
// - Pin-state holds in manual reset, soft standby
// - Pin selection independent of chip mode
// - Timer 1 output select claims pin 7
// - Channel 5 B output on pin 7
// - Pin 7 feeds channel 5 B capture
// - Timer 0 output select claims pin 6
// - Channel 5 A output on pin 6
// - PWM mode 1 disables B output
// - Pin 6 feeds channel 5 A capture
// - Pin 5 is timer 1 clock input
// - Pin 5 role from channel 4, direction
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module p2io_port #(
    parameter int          WIDTH     = 8,          // Port width
    parameter logic [7:0]  DDR_RDVAL = p2io_pkg::DIRECTION_READ_VALUE
) (
    // Clock and power-on reset
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    // Low-power and reset conditions
    input  wire logic                     hw_standby,
    input  wire logic                     sw_standby,
    input  wire logic                     manual_reset,
    // Register port
    input  wire logic [15:0]              reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    // Pulse-unit channel settings
    input  wire p2io_pkg::p2io_chan_cfg_s chan5_cfg,
    input  wire p2io_pkg::p2io_chan_cfg_s chan4_cfg,
    // Pulse-unit waveforms toward the pins
    input  wire logic                     chan5_a_pin,
    input  wire logic                     chan5_b_pin,
    input  wire logic                     chan4_b_pin,
    // Eight-bit timer settings and waveforms
    input  wire logic [3:0]               timer0_output_select,
    input  wire logic [3:0]               timer1_output_select,
    input  wire logic [2:0]               timer1_clock_select,
    input  wire logic                     timer0_compare_out,
    input  wire logic                     timer1_compare_out,
    // Capture and clock inputs toward the timers
    output logic                          chan5_a_capture_in,
    output logic                          chan5_b_capture_in,
    output logic                          chan4_b_capture_in,
    output logic                          timer1_ext_clock_in,
    // Pins
    input  wire logic [WIDTH-1:0]         pin_in,
    output logic      [WIDTH-1:0]         pin_out,
    output logic      [WIDTH-1:0]         pin_oe
);

    // Notes on the mux as a whole:
    // Each multiplexed pin is resolved in a fixed order.
    // An 8-bit timer output select wins first,
    // then the pulse-unit channel output,
    // then the plain direction and latch bits.
    // Capture and clock inputs never steal a pin;
    // they only watch the level seen on pin_in.
    // A pin that is an output still feeds captures,
    // so a channel can capture an 8-bit timer or latch level driven on its pin.
    // Pins 4 to 0 are plain port bits here;
    // their timer roles live in a neighbouring block.
    // Chip operating mode has no input at all,
    // which keeps every pin choice mode-free.
    //
    // Notes on timing:
    // Pin drive paths are combinational on purpose,
    // so a timer waveform reaches its pin with no
    // extra flop delay; the cost is a longer path
    // from the timer settings to the pad.
    // Register reads are registered: data stand in
    // the cycle after the read strobe, else zero.
    //
    // Notes on resets and low power:
    // Power-on reset and hardware standby clear
    // direction and latch; manual reset and
    // software standby keep them untouched.
    // Manual reset also holds the pin sample,
    // so software sees the last levels it saw.
    // Hardware standby floats every pin at once,
    // before the clearing edge has even come.
    //
    // Limitation: the direction register reads
    // back a fixed value, never its contents;
    // software must keep its own shadow copy.

    // Compare-output codes: 0001..0011 and 0101..0111
    function automatic logic is_compare_io(input logic [3:0] io);
        is_compare_io = (io[3] == 1'b0) && (io[1:0] != 2'b00);
    endfunction : is_compare_io

    // Codes that leave the pin alone in PWM modes: xx00
    function automatic logic is_io_active(input logic [3:0] io);
        is_io_active = (io[1:0] != 2'b00);
    endfunction : is_io_active

    // Normal mode or any phase-counting mode (01xx)
    function automatic logic is_normal_or_phase(input logic [3:0] mode);
        is_normal_or_phase = (mode == p2io_pkg::MODE_NORMAL)
                           || (mode[3:2] == p2io_pkg::MODE_PHASE_TOP);
    endfunction : is_normal_or_phase

    // Capture set in normal mode (1xxx)
    function automatic logic is_capture(input logic [3:0] mode, input logic [3:0] io);
        is_capture = (mode == p2io_pkg::MODE_NORMAL) && io[3];
    endfunction : is_capture

    // Register state and its next value
    p2io_pkg::p2io_state_s state_reg;
    p2io_pkg::p2io_state_s state_next;

    // Decoded accesses
    logic       hit_direction;  // Address hits direction register
    logic       hit_pin_level;  // Address hits pin-state register
    logic       hit_latch;      // Address hits output latch
    logic       regs_clear;     // Power-on reset or hardware standby
    logic       timers_live;    // Timer functions may claim pins

    // Pin-claim decisions
    logic       t1_claims_p7;   // Timer 1 compare out owns pin 7
    logic       t0_claims_p6;   // Timer 0 compare out owns pin 6
    logic       c5a_drives;     // Channel 5 A output on pin 6
    logic       c5a_pwm1;       // Channel 5 in PWM mode 1 on A
    logic       c5b_drives;     // Channel 5 B output on pin 7
    logic       c4b_drives;     // Channel 4 B output on pin 5
    logic [7:0] pin_view;       // Pin-state register read value

    // Address decode
    always_comb
    begin
        hit_direction = (reg_addr == p2io_pkg::ADDR_DIRECTION);
        hit_pin_level = (reg_addr == p2io_pkg::ADDR_PIN_LEVEL);
        hit_latch     = (reg_addr == p2io_pkg::ADDR_OUTPUT_LATCH);
    end

    // Clearing and timer-gating conditions
    always_comb
    begin
        // Power-on reset and hardware standby clear the stored registers
        regs_clear  = srst || hw_standby;
        // Timers sit in their initial state during manual reset, so
        // only the retained port registers decide the pins
        timers_live = !manual_reset && !regs_clear;
    end

    // Timer claim decisions; no chip-mode input exists on purpose
    always_comb
    begin
        // Any output-select bit set hands the pin to the 8-bit timer
        t1_claims_p7 = timers_live && (timer1_output_select != 4'h0);
        t0_claims_p6 = timers_live && (timer0_output_select != 4'h0);

        // PWM mode 1 on A; it also silences the B output
        c5a_pwm1 = (chan5_cfg.channel_mode_field == p2io_pkg::MODE_PWM1)
                 && is_io_active(chan5_cfg.a_io_control_field);

        // Channel 5 A: compare, PWM 1 or PWM 2 output
        c5a_drives = timers_live && (
              (is_normal_or_phase(chan5_cfg.channel_mode_field)
                && is_compare_io(chan5_cfg.a_io_control_field))
            || c5a_pwm1
            || ((chan5_cfg.channel_mode_field == p2io_pkg::MODE_PWM2)
                && is_io_active(chan5_cfg.a_io_control_field)
                && (chan5_cfg.counter_clear_select != p2io_pkg::CCLR_STOPS_A)));

        // Channel 5 B: compare or PWM 2 output; PWM 1 excluded
        c5b_drives = timers_live && (
              (is_normal_or_phase(chan5_cfg.channel_mode_field)
                && is_compare_io(chan5_cfg.b_io_control_field))
            || ((chan5_cfg.channel_mode_field == p2io_pkg::MODE_PWM2)
                && is_io_active(chan5_cfg.b_io_control_field)
                && (chan5_cfg.counter_clear_select != p2io_pkg::CCLR_STOPS_B)));

        // Channel 4 B: same selection shape as channel 5 B
        c4b_drives = timers_live && (
              (is_normal_or_phase(chan4_cfg.channel_mode_field)
                && is_compare_io(chan4_cfg.b_io_control_field))
            || ((chan4_cfg.channel_mode_field == p2io_pkg::MODE_PWM2)
                && is_io_active(chan4_cfg.b_io_control_field)
                && (chan4_cfg.counter_clear_select != p2io_pkg::CCLR_STOPS_B)));
    end

    // Pin drivers: timer claims first, then direction and latch
    always_comb
    begin
        // Unclaimed pins: direction picks drive, latch gives level
        pin_out = state_reg.output_latch;
        pin_oe  = state_reg.direction;

        // Pin 7: timer 1 beats channel 5 B
        if (t1_claims_p7)
        begin
            pin_out[p2io_pkg::PIN_CHAN5_B] = timer1_compare_out;
            pin_oe[p2io_pkg::PIN_CHAN5_B]  = 1'b1;
        end
        else if (c5b_drives)
        begin
            pin_out[p2io_pkg::PIN_CHAN5_B] = chan5_b_pin;
            pin_oe[p2io_pkg::PIN_CHAN5_B]  = 1'b1;
        end

        // Pin 6: timer 0 beats channel 5 A
        if (t0_claims_p6)
        begin
            pin_out[p2io_pkg::PIN_CHAN5_A] = timer0_compare_out;
            pin_oe[p2io_pkg::PIN_CHAN5_A]  = 1'b1;
        end
        else if (c5a_drives)
        begin
            pin_out[p2io_pkg::PIN_CHAN5_A] = chan5_a_pin;
            pin_oe[p2io_pkg::PIN_CHAN5_A]  = 1'b1;
        end

        // Pin 5: channel 4 B output, else direction bit decides
        if (c4b_drives)
        begin
            pin_out[p2io_pkg::PIN_CHAN4_B] = chan4_b_pin;
            pin_oe[p2io_pkg::PIN_CHAN4_B]  = 1'b1;
        end

        // Hardware standby floats every pin
        if (hw_standby)
        begin
            pin_oe = '0;
        end
    end

    // Inputs handed to the timers; they see the pin level only while timers are live and the input is selected, else zero
    always_comb
    begin
        // Capture inputs only in normal mode with capture set
        chan5_b_capture_in = timers_live
            && is_capture(chan5_cfg.channel_mode_field, chan5_cfg.b_io_control_field)
            && pin_in[p2io_pkg::PIN_CHAN5_B];
        chan5_a_capture_in = timers_live
            && is_capture(chan5_cfg.channel_mode_field, chan5_cfg.a_io_control_field)
            && pin_in[p2io_pkg::PIN_CHAN5_A];
        chan4_b_capture_in = timers_live
            && is_capture(chan4_cfg.channel_mode_field, chan4_cfg.b_io_control_field)
            && pin_in[p2io_pkg::PIN_CHAN4_B];
        // External clock reaches timer 1 only when selected
        timer1_ext_clock_in = timers_live
            && (timer1_clock_select >= p2io_pkg::CKS_EXT_FIRST)
            && pin_in[p2io_pkg::PIN_CHAN4_B];
    end

    // Pin-state view: latch for outputs, sampled level for inputs
    always_comb
    begin
        pin_view = (state_reg.direction & state_reg.output_latch)
                 | (~state_reg.direction & state_reg.pin_sample);
    end

    // Next-state logic for all registers.
    // Order of the steps below matters:
    // first the pin sample, then bus writes,
    // then read data, and last the clears,
    // so a clear always beats a write
    // landing in the same cycle.
    // A write to the pin-state address is
    // dropped rather than redirected, so a
    // careless store cannot move any pin.
    // The unmapped read value is fixed,
    // which keeps the read mux free of
    // anything left from an earlier read.
    // Read data are rebuilt every cycle;
    // nothing of an old read survives
    // into the next cycle's answer.
    // The pin sample is taken one cycle
    // before the read that returns it,
    // so inputs read one cycle late.
    // That delay is the price of holding
    // the sample in manual reset and
    // software standby without a mux
    // on the read path.
    // Bits set as outputs read the latch,
    // never the pad, so a loaded pin
    // cannot corrupt a read-modify-write.
    // Only state_reg is a flip-flop here;
    // every other signal is combinational.
    always_comb
    begin
        state_next = state_reg;

        // Pin sample follows the pins except while held
        if (!(manual_reset || sw_standby) || regs_clear)
        begin
            state_next.pin_sample = pin_in;
        end

        // Writes; the pin-state address takes no write
        if (reg_wr && !regs_clear)
        begin
            if (hit_direction)
            begin
                state_next.direction = reg_wdata;
            end
            if (hit_latch)
            begin
                state_next.output_latch = reg_wdata;
            end
            // Writes to the pin-state address are dropped
        end

        // Read data stands only in the cycle after the strobe
        state_next.rdata = 8'h00;
        if (reg_rd)
        begin
            if (hit_direction)
            begin
                // Stored setting is never returned
                state_next.rdata = DDR_RDVAL;
            end
            else if (hit_latch)
            begin
                state_next.rdata = state_reg.output_latch;
            end
            else if (hit_pin_level)
            begin
                state_next.rdata = pin_view;
            end
            else
            begin
                state_next.rdata = p2io_pkg::UNMAPPED_READ_VALUE;
            end
        end

        // Power-on reset and hardware standby clear the port registers;
        // manual reset and software standby leave them as they were
        if (regs_clear)
        begin
            state_next.direction    = p2io_pkg::DIRECTION_RESET;
            state_next.output_latch = p2io_pkg::OUTPUT_LATCH_RESET;
            state_next.rdata        = 8'h00;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Read data from the flip-flop
    assign reg_rdata = state_reg.rdata;

endmodule : p2io_port
`default_nettype wire

// *** test/p2io_chk.sv ***
// Checker: concurrent properties on the port two I/O block's ports
`timescale 1ns/100ps
`default_nettype none
module p2io_chk (
    // Clock and conditions
    input wire logic                     ref_clk,
    input wire logic                     srst,
    input wire logic                     hw_standby,
    input wire logic                     manual_reset,
    // Register port
    input wire logic [15:0]              reg_addr,
    input wire logic [7:0]               reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [7:0]               reg_rdata,
    // Timer side
    input wire p2io_pkg::p2io_chan_cfg_s chan5_cfg,
    input wire logic [3:0]               timer1_output_select,
    input wire logic [2:0]               timer1_clock_select,
    input wire logic                     timer1_compare_out,
    input wire logic                     timer1_ext_clock_in,
    // Pins
    input wire logic [7:0]               pin_in,
    input wire logic [7:0]               pin_out,
    input wire logic [7:0]               pin_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // PWM 1 with timer 1 idle: pin 7 must not follow the B waveform
    logic pwm1_quiet;
    assign pwm1_quiet = chan5_cfg.channel_mode_field == 4'h2 && timer1_output_select == 4'h0;
    property p_ddr_read; reg_rd && reg_addr == 16'hFEB1 |=> reg_rdata == 8'h00; endproperty
    a_ddr_read: assert property (p_ddr_read)
        else $error("direction read gave data");
    property p_latch_rw;
        reg_wr && reg_addr == 16'hFF61 && !hw_standby ##1 (!reg_wr && !hw_standby) [*2]
            ##1 reg_rd && reg_addr == 16'hFF61 |=> reg_rdata == $past(reg_wdata, 4);
    endproperty
    a_latch_rw: assert property (p_latch_rw)
        else $error("latch read back differs");
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    property p_hw_float; hw_standby |-> pin_oe == 8'h00; endproperty
    a_hw_float: assert property (p_hw_float)
        else $error("pin driven in standby");
    // Only a register write may move the pins while timers are held
    property p_manual_hold;
        manual_reset && !hw_standby && !reg_wr ##1 manual_reset && !hw_standby
            |-> $stable(pin_oe) && $stable(pin_out);
    endproperty
    a_manual_hold: assert property (p_manual_hold)
        else $error("pins moved during manual reset");
    property p_t1_claim;
        !manual_reset && !hw_standby && timer1_output_select != 4'h0
            |-> pin_oe[7] && pin_out[7] == timer1_compare_out;
    endproperty
    a_t1_claim: assert property (p_t1_claim)
        else $error("pin 7 not on timer 1 output");
    property p_pwm1_b;
        pwm1_quiet && !reg_wr && !hw_standby ##1 pwm1_quiet && !hw_standby
            |-> $stable(pin_out[7]) && $stable(pin_oe[7]);
    endproperty
    a_pwm1_b: assert property (p_pwm1_b)
        else $error("pin 7 moved in PWM 1");
    property p_ext_clock;
        !manual_reset && !hw_standby
            |-> timer1_ext_clock_in == (timer1_clock_select >= 3'h5 && pin_in[5]);
    endproperty
    a_ext_clock: assert property (p_ext_clock)
        else $error("timer 1 clock input wrong");
endmodule : p2io_chk
`default_nettype wire

// *** test/p2io_pins_model.sv ***
// Pin model: resolves each port pin from device drive and outside level
`timescale 1ns/100ps
`default_nettype none
module p2io_pins_model (
    // Device side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // Outside world
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_in
);
    // Driven bits show the device, the rest the outside driver
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : p2io_pins_model
`default_nettype wire

// *** test/port_two_io_with_timer_mux_bench.sv ***
// Bench for the port two I/O block: registers, pin mux and resets
`timescale 1ns/100ps
`default_nettype none
module port_two_io_with_timer_mux_bench;
    logic ref_clk, srst, hw_standby, sw_standby, manual_reset, reg_wr, reg_rd;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, ext_level, pin_in, pin_out, pin_oe;
    p2io_pkg::p2io_chan_cfg_s chan5_cfg, chan4_cfg;
    logic c5a, c5b, c4b, t0_cmp, t1_cmp, cap_a, cap_b, cap4, ext_clk;
    logic [5:0]  e;
    logic [3:0]  t0_os, t1_os;
    logic [2:0]  t1_cks;
    logic [3:0]  modes [4];
    int          n_errors, n_tests;
    // Channel 4 follows channel 5 settings so pin 5 is swept too
    p2io_port dut_u (
        .ref_clk(ref_clk), .srst(srst), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .manual_reset(manual_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan5_cfg(chan5_cfg),
        .chan4_cfg(chan4_cfg), .chan5_a_pin(c5a), .chan5_b_pin(c5b), .chan4_b_pin(c4b),
        .timer0_output_select(t0_os), .timer1_output_select(t1_os),
        .timer1_clock_select(t1_cks), .timer0_compare_out(t0_cmp),
        .timer1_compare_out(t1_cmp), .chan5_a_capture_in(cap_a), .chan5_b_capture_in(cap_b),
        .chan4_b_capture_in(cap4), .timer1_ext_clock_in(ext_clk), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    p2io_pins_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
    endtask : rdc
    // Expected {pin 7 out, pin 6 out, pin 7 oe, pin 6 oe, B capture, A capture}
    function automatic logic [5:0] mux_exp(input logic [3:0] m, input logic [3:0] io,
                                           input logic [1:0] cc);
        logic drv, cmp, a, b;
        drv = io[1:0] != 2'h0;
        cmp = (m == 4'h0 || m[3:2] == 2'h1) && drv && !io[3];
        a = cmp || drv && (m == 4'h2 || m == 4'h3 && cc != 2'h1);
        b = cmp || drv && m == 4'h3 && cc != 2'h2;
        return {b & io[0], a & io[0], b, a, m == 4'h0 && io[3], m == 4'h0 && io[3]};
    endfunction : mux_exp
    task automatic finish_test;
        $display("mismatches %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // Watchdog: the sequence needs well under 2000 cycles
    initial
    begin
        #20000;
        n_errors++;
        finish_test();
    end
    initial
    begin
        {srst, hw_standby, sw_standby, manual_reset, reg_wr, reg_rd} = 6'h20;
        {chan4_cfg, c4b} = '0;
        {reg_addr, reg_wdata, ext_level} = {16'h0000, 8'h00, 8'h3C};
        {chan5_cfg, c5a, c5b, t0_cmp, t1_cmp, t0_os, t1_os, t1_cks} = '0;
        modes = '{4'h0, 4'h2, 4'h3, 4'h4};
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk8(pin_oe, 8'h00);
        rdc(16'hFF61, 8'h00);
        rdc(16'hFEB1, 8'h00);
        $display("reset values done");
        wr(16'hFEB1, 8'hF0);
        wr(16'hFF61, 8'hA5);
        rdc(16'hFF61, 8'hA5);
        chk8(pin_oe, 8'hF0);
        chk8(pin_out & pin_oe, 8'hA0);
        rdc(16'hFF51, 8'hAC);
        wr(16'hFF51, 8'h5A);
        rdc(16'hFF61, 8'hA5);
        rdc(16'hFF51, 8'hAC);
        rdc(16'h1234, 8'h00);
        $display("register access done");
        for (int i = 0; i < 2; i++)
        begin
            @(posedge ref_clk);
            {t1_os, t0_os, t1_cmp, t0_cmp} <= {4'h8, 4'h1, i[0], !i[0]};
            #1;
            chk8({4'h0, pin_oe[7:6], pin_out[7:6]}, {6'h03, i[0], !i[0]});
        end
        $display("timer claims done");
        wr(16'hFEB1, 8'h00);
        @(posedge ref_clk);
        {t1_os, t0_os, ext_level} <= {8'h00, 8'hFF};
        // Modes 0, 2, 3 and 4, every clear select and control code on both channel 5 pins
        foreach (modes[k])
            for (int cc = 0; cc < 4; cc++)
                for (int io = 0; io < 16; io++)
                begin
                    @(posedge ref_clk);
                    chan5_cfg <= '{modes[k], io[3:0], io[3:0], cc[1:0]};
                    chan4_cfg <= '{modes[k], io[3:0], io[3:0], cc[1:0]};
                    {c5a, c5b, c4b} <= {3{io[0]}};
                    #1;
                    e = mux_exp(modes[k], io[3:0], cc[1:0]);
                    chk8({5'h0, pin_out[5] & pin_oe[5], pin_oe[5], cap4},
                        {5'h0, e[5], e[3], e[1]});
                    chk8({2'h0, pin_out[7:6] & pin_oe[7:6], pin_oe[7:6], cap_b, cap_a},
                        {2'h0, mux_exp(modes[k], io[3:0], cc[1:0])});
                end
        $display("channel 5 mux done");
        for (int c = 0; c < 8; c++)
        begin
            @(posedge ref_clk);
            t1_cks <= c[2:0];
            #1;
            chk8({7'h00, ext_clk}, {7'h00, c >= 5});
        end
        $display("timer clock input done");
        wr(16'hFEB1, 8'h81);
        @(posedge ref_clk);
        {t1_os, manual_reset} <= {4'h1, 1'b1};
        #1;
        chk8(pin_oe, 8'h81);
        chk8(pin_out & pin_oe, 8'h81);
        @(posedge ref_clk);
        {ext_level, t1_cmp} <= {8'h00, 1'b1};
        rdc(16'hFF51, 8'hFF);
        rdc(16'hFF61, 8'hA5);
        @(posedge ref_clk);
        manual_reset <= 1'b0;
        rdc(16'hFF51, 8'h81);
        @(posedge ref_clk);
        sw_standby <= 1'b1;
        @(posedge ref_clk);
        ext_level <= 8'hFF;
        rdc(16'hFF51, 8'h81);
        $display("manual reset and soft standby done");
        @(posedge ref_clk);
        {sw_standby, hw_standby} <= 2'h1;
        #1;
        chk8(pin_oe, 8'h00);
        @(posedge ref_clk);
        hw_standby <= 1'b0;
        rdc(16'hFF61, 8'h00);
        rdc(16'hFF51, 8'hFF);
        $display("hardware standby done");
        finish_test();
    end
endmodule : port_two_io_with_timer_mux_bench
bind p2io_port p2io_chk chk_u (
    .ref_clk(ref_clk), .srst(srst), .hw_standby(hw_standby), .manual_reset(manual_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan5_cfg(chan5_cfg), .timer1_output_select(timer1_output_select),
    .timer1_clock_select(timer1_clock_select), .timer1_compare_out(timer1_compare_out),
    .timer1_ext_clock_in(timer1_ext_clock_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
`default_nettype wire
